/* File: hw/lcdt_defs.svh */
`ifndef LCDT_DEFS_SVH
`define LCDT_DEFS_SVH

`define LCDT_CASE_1 3'h5
`define LCDT_CASE_2 3'h4
`define LCDT_CASE_3 3'h3
`define LCDT_CASE_4 3'h2
`define LCDT_CASE_5 3'h1
`define LCDT_CASE_6 3'h0
`define LCDT_CFG_DIR_BIT 3
`define LCDT_CFG_RESET 4'h0
`define LCDT_ROW_BITS 166
`define LCDT_SEG_ONLY 70
`define LCDT_DUAL 96
`define LCDT_SMALL_SEGS 150
`define LCDT_SMALL_COMS 16
`define LCDT_DIV_LARGE 4
`define LCDT_DIV_MID 8
`define LCDT_DIV_SMALL 16
`define LCDT_DUTY_RESET 7'h40
`define LCDT_INV_N_RESET 6'h0D

`endif

/* File: hw/lcdt_pkg.sv */
package lcdt_pkg;
  typedef enum logic [1:0] {
    LCDT_VAR_LARGE,
    LCDT_VAR_MID,
    LCDT_VAR_SMALL
  } lcdt_variant_t;

  typedef enum logic [1:0] {
    LCDT_LVL_SEL_IDLE,
    LCDT_LVL_SEL_ON,
    LCDT_LVL_COM_IDLE,
    LCDT_LVL_COM_ON
  } lcdt_level_t;

  typedef struct packed {
    logic normal_inverse;
    logic display_on;
    logic all_points_on;
    logic line_inv_en;
    logic [5:0] line_inv_n;
    logic [6:0] duty;
    logic duty_plus_one;
  } lcdt_disp_cfg_t;

  typedef struct packed {
    logic power_on;
    logic strap_a;
    logic strap_b;
  } lcdt_pwr_in_t;

  typedef struct packed {
    logic tripler_en;
    logic regulator_en;
    logic follower_en;
  } lcdt_pwr_out_t;
endpackage

/* File: hw/lcdt_osc_div.sv */
module lcdt_osc_div (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic run,
  input wire logic [4:0] ratio,
  output logic tick,
  output logic div_level
);
  import lcdt_pkg::*;

  typedef struct packed {
    logic [4:0] cnt;
    logic tick;
    logic level;
  } lcdt_div_state_t;

  lcdt_div_state_t s_q;
  lcdt_div_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (!run) begin
      s_d.cnt = 5'h00;
      s_d.level = 1'b0;
    end else if (s_q.cnt == ratio - 5'h01) begin
      s_d.cnt = 5'h00;
      s_d.tick = 1'b1;
      s_d.level = 1'b0;
    end else begin
      s_d.cnt = s_q.cnt + 5'h01;
      if (s_q.cnt == (ratio >> 1) - 5'h01) begin
        s_d.level = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
  assign div_level = s_q.level;
endmodule

/* File: hw/lcdt_line_timing.sv */
`include "lcdt_defs.svh"

module lcdt_line_timing (
  input wire logic clk_sys,
  input wire logic rst,
  input wire lcdt_pkg::lcdt_variant_t variant,
  input wire logic master_mode,
  input wire logic osc_in,
  input wire logic display_clk,
  input wire logic cfg_we,
  input wire logic [3:0] cfg_wdata,
  input wire lcdt_pkg::lcdt_disp_cfg_t disp_cfg,
  input wire logic [5:0] start_line,
  input wire logic [`LCDT_ROW_BITS-1:0] ram_row,
  input wire logic frame_polarity_in,
  input wire logic frame_sync_in,
  input wire lcdt_pkg::lcdt_pwr_in_t pwr_in,
  output logic [6:0] ram_line_addr,
  output logic [`LCDT_ROW_BITS-1:0] row_latch,
  output logic frame_polarity_out,
  output logic frame_polarity_oe,
  output logic frame_sync_out,
  output logic frame_sync_oe,
  output logic divided_clk_out,
  output logic divided_clk_oe,
  output logic common_start_pulse,
  output logic osc_out,
  output logic [3:0] output_config,
  output logic [`LCDT_DUAL-1:0] dual_is_com,
  output logic [`LCDT_DUAL-1:0] com_scan,
  output logic [2*(`LCDT_ROW_BITS+1)-1:0] out_level,
  output lcdt_pkg::lcdt_pwr_out_t pwr_out
);
  import lcdt_pkg::*;

  localparam int NOUT = `LCDT_ROW_BITS + 1;

  typedef struct packed {
    logic [2:0] clk_sy;
    logic [2:0] fp_sy;
    logic [2:0] fs_sy;
    logic clk_st;
    logic fs_st;
    logic [3:0] cfg;
    logic [6:0] line;
    logic [6:0] addr;
    logic [5:0] inv_cnt;
    logic fp;
    logic fs;
    logic start;
    logic [NOUT-1:0] latch;
    logic [`LCDT_DUAL-1:0] scan;
    logic [`LCDT_DUAL-1:0] dual_com;
    logic [2*NOUT-1:0] lvl;
    logic osc_q;
    lcdt_pwr_out_t pwr;
  } lcdt_state_t;

  lcdt_state_t s_q;
  lcdt_state_t s_d;
  logic osc_tick;
  logic osc_level;
  logic [4:0] div_ratio;

  function automatic logic case_ok(input lcdt_variant_t v, input logic [2:0] c);
    case (v)
      LCDT_VAR_LARGE: case_ok = (c == `LCDT_CASE_1) || (c == `LCDT_CASE_2) || (c == `LCDT_CASE_6);
      LCDT_VAR_MID: case_ok = (c == `LCDT_CASE_3) || (c == `LCDT_CASE_4) ||
                              (c == `LCDT_CASE_5) || (c == `LCDT_CASE_6);
      default: case_ok = 1'b0;
    endcase
  endfunction

  // Dual index 0..31 maps to O0..O31, 32..95 to O102..O165.
  function automatic logic [`LCDT_DUAL-1:0] com_map(input lcdt_variant_t v, input logic [2:0] c);
    logic [`LCDT_DUAL-1:0] m;
    m = '0;
    if (v == LCDT_VAR_SMALL) begin
      m[95:80] = '1;
    end else begin
      case (c)
        `LCDT_CASE_1: m[95:32] = '1;
        // Case 2 splits the commons over both ends of the dual range.
        `LCDT_CASE_2: begin
          m[31:0] = '1;
          m[95:64] = '1;
        end
        `LCDT_CASE_3: m[31:0] = '1;
        `LCDT_CASE_4: m[95:64] = '1;
        `LCDT_CASE_5: begin
          m[15:0] = '1;
          m[95:80] = '1;
        end
        default: m = '0;
      endcase
    end
    com_map = m;
  endfunction

  function automatic logic [`LCDT_DUAL-1:0] bitrev(input logic [`LCDT_DUAL-1:0] x);
    logic [`LCDT_DUAL-1:0] r;
    r = '0;
    for (int i = 0; i < `LCDT_DUAL; i++) begin
      r[i] = x[`LCDT_DUAL-1-i];
    end
    bitrev = r;
  endfunction

  function automatic logic [1:0] level_of(input logic is_com, input logic on, input logic fp);
    if (is_com) begin
      level_of = on ? (fp ? 2'(LCDT_LVL_COM_ON) : 2'(LCDT_LVL_SEL_ON)) : 2'(LCDT_LVL_COM_IDLE);
    end else begin
      level_of = (on ^ fp) ? 2'(LCDT_LVL_SEL_ON) : 2'(LCDT_LVL_SEL_IDLE);
    end
  endfunction

  always_comb begin
    case (variant)
      LCDT_VAR_LARGE: div_ratio = 5'(`LCDT_DIV_LARGE);
      LCDT_VAR_MID: div_ratio = 5'(`LCDT_DIV_MID);
      default: div_ratio = 5'(`LCDT_DIV_SMALL);
    endcase
  end

  // The oscillator is stopped in slave mode, so the clock pin then steps the lines and the sync and polarity pins set frame and polarity.
  lcdt_osc_div u_div (
    .clk_sys(clk_sys),
    .rst(rst),
    .run(master_mode),
    .ratio(div_ratio),
    .tick(osc_tick),
    .div_level(osc_level)
  );

  always_comb begin
    logic cl_rise;
    logic fs_edge;
    logic frame_start;
    logic [NOUT-1:0] row;
    logic [`LCDT_DUAL-1:0] first;
    logic [6:0] half;
    cl_rise = 1'b0;
    fs_edge = 1'b0;
    frame_start = 1'b0;
    row = '0;
    first = '0;
    half = 7'h00;
    s_d = s_q;
    s_d.clk_sy = {s_q.clk_sy[1:0], display_clk};
    s_d.fp_sy = {s_q.fp_sy[1:0], frame_polarity_in};
    s_d.fs_sy = {s_q.fs_sy[1:0], frame_sync_in};
    s_d.osc_q = master_mode & ~osc_in;
    if (s_q.clk_sy[2] == s_q.clk_sy[1]) begin
      s_d.clk_st = s_q.clk_sy[2];
    end
    if (s_q.fs_sy[2] == s_q.fs_sy[1]) begin
      s_d.fs_st = s_q.fs_sy[2];
    end
    if (cfg_we && (variant != LCDT_VAR_SMALL) && case_ok(variant, cfg_wdata[2:0])) begin
      s_d.cfg = cfg_wdata;
    end
    s_d.dual_com = com_map(variant, s_q.cfg[2:0]);
    // Display clock: internal divided oscillator in master mode, the pin otherwise.
    cl_rise = master_mode ? osc_tick : (s_d.clk_st & ~s_q.clk_st);
    fs_edge = (s_d.fs_st != s_q.fs_st);
    s_d.start = 1'b0;
    half = {1'b0, disp_cfg.duty[6:1]};
    if (cl_rise) begin
      if (master_mode) begin
        frame_start = (s_q.line == disp_cfg.duty - 7'h01);
        if (frame_start) begin
          s_d.fs = 1'b1;
        end else if (s_q.line == half - 7'h01) begin
          s_d.fs = 1'b0;
        end
        // Pulse only where sync really moves, so the half frame after reset gives no stray pulse.
        if (s_d.fs != s_q.fs) begin
          s_d.start = 1'b1;
        end
      end
      s_d.line = frame_start ? 7'h00 : s_q.line + 7'h01;
      s_d.addr = frame_start ? {1'b0, start_line} : s_q.addr + 7'h01;
      if (disp_cfg.duty_plus_one && (s_d.line == disp_cfg.duty)) begin
        s_d.addr = 7'h40;
      end
      row = {1'b0, ram_row};
      if (disp_cfg.all_points_on) begin
        row = '1;
      end else if (disp_cfg.normal_inverse) begin
        row = ~row;
      end
      if (!disp_cfg.display_on) begin
        row = '0;
      end
      s_d.latch = row;
      first = '0;
      first[0] = 1'b1;
      s_d.scan = frame_start ? first : {s_q.scan[`LCDT_DUAL-2:0], s_q.scan[`LCDT_DUAL-1]};
      if (disp_cfg.line_inv_en) begin
        if (frame_start || s_q.inv_cnt == disp_cfg.line_inv_n - 6'h01) begin
          s_d.inv_cnt = 6'h00;
          if (!frame_start) begin
            s_d.fp = ~s_q.fp;
          end
        end else begin
          s_d.inv_cnt = s_q.inv_cnt + 6'h01;
        end
      end else if (frame_start) begin
        s_d.fp = ~s_q.fp;
      end
    end
    if (!master_mode) begin
      s_d.fp = s_q.fp_sy[2];
      if (fs_edge && s_d.fs_st) begin
        s_d.line = 7'h00;
        s_d.addr = {1'b0, start_line};
        s_d.inv_cnt = 6'h00;
        s_d.scan = '0;
        s_d.scan[0] = 1'b1;
      end
      // Slave flags the sync change four system-clock edges late, after the pin synchroniser; the master's own pulse is the exact one.
      s_d.start = fs_edge;
    end
    for (int i = 0; i < NOUT; i++) begin
      s_d.lvl[2*i +: 2] = level_of(1'b0, s_q.latch[i], s_q.fp);
    end
    for (int j = 0; j < `LCDT_DUAL; j++) begin
      logic [`LCDT_DUAL-1:0] sc;
      int k;
      sc = s_q.cfg[`LCDT_CFG_DIR_BIT] ? bitrev(s_q.scan) : s_q.scan;
      k = (j < 32) ? j : j + `LCDT_SEG_ONLY;
      if (s_q.dual_com[j]) begin
        s_d.lvl[2*k +: 2] = level_of(1'b1, sc[j], s_q.fp);
      end
    end
    s_d.lvl[2*(NOUT-1) +: 2] = level_of(1'b1, s_q.line == disp_cfg.duty, s_q.fp);
    s_d.pwr.tripler_en = master_mode & pwr_in.power_on & ~pwr_in.strap_a;
    s_d.pwr.regulator_en = master_mode & pwr_in.power_on & ~(pwr_in.strap_a & pwr_in.strap_b);
    s_d.pwr.follower_en = master_mode & pwr_in.power_on;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= '0;
      s_q.cfg <= `LCDT_CFG_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  logic div_q;
  logic [1:0] oe_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_q <= 1'b0;
      oe_q <= 2'b00;
    end else begin
      div_q <= osc_level;
      oe_q <= {master_mode, master_mode};
    end
  end

  assign ram_line_addr = s_q.addr;
  assign row_latch = s_q.latch[`LCDT_ROW_BITS-1:0];
  assign frame_polarity_out = s_q.fp;
  assign frame_polarity_oe = oe_q[0];
  assign frame_sync_out = s_q.fs;
  assign frame_sync_oe = oe_q[0];
  assign divided_clk_out = div_q;
  assign divided_clk_oe = oe_q[1];
  assign common_start_pulse = s_q.start;
  assign osc_out = s_q.osc_q;
  assign output_config = s_q.cfg;
  assign dual_is_com = s_q.dual_com;
  assign com_scan = s_q.scan;
  assign out_level = s_q.lvl;
  assign pwr_out = s_q.pwr;
endmodule

/* File: test/lcdt_line_timing_monitor.sv */
module lcdt_line_timing_monitor (
  input wire logic clk_sys,
  input wire logic rst,
  input wire lcdt_pkg::lcdt_variant_t variant,
  input wire logic master_mode,
  input wire lcdt_pkg::lcdt_pwr_in_t pwr_in,
  input wire logic frame_sync_out,
  input wire logic frame_sync_oe,
  input wire logic divided_clk_oe,
  input wire logic common_start_pulse,
  input wire logic [3:0] output_config,
  input wire lcdt_pkg::lcdt_pwr_out_t pwr_out
);
  import lcdt_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire logic off_in = !pwr_in.power_on || !master_mode;
  wire logic sab = pwr_in.strap_a && pwr_in.strap_b;
  wire logic sa = pwr_in.strap_a && !pwr_in.strap_b;
  property p_large;
    variant == LCDT_VAR_LARGE |-> output_config[2:0] inside {3'h5, 3'h4, 3'h0};
  endproperty
  a_large: assert property (p_large) else $error("large variant holds an unsupported case");
  property p_mid;
    variant == LCDT_VAR_MID |-> output_config[2:0] inside {3'h3, 3'h2, 3'h1, 3'h0};
  endproperty
  a_mid: assert property (p_mid) else $error("mid variant holds an unsupported case");
  property p_small;
    variant == LCDT_VAR_SMALL |-> output_config == 4'h0;
  endproperty
  a_small: assert property (p_small) else $error("small variant output selection moved");
  property p_slave_pins;
    $past(!master_mode, 2) && $past(!master_mode) && !master_mode |-> !divided_clk_oe && !frame_sync_oe;
  endproperty
  a_slave_pins: assert property (p_slave_pins) else $error("slave drives clock or sync pin");
  property p_start;
    common_start_pulse && master_mode && frame_sync_oe |-> frame_sync_out != $past(frame_sync_out);
  endproperty
  a_start: assert property (p_start) else $error("start pulse not followed by sync change");
  property p_off;
    $past(off_in, 2) && $past(off_in) && off_in |-> pwr_out == 3'h0;
  endproperty
  a_off: assert property (p_off) else $error("power blocks on while off or slave");
  property p_strap_hh;
    $past(sab, 2) && $past(sab) && sab |-> !pwr_out.tripler_en && !pwr_out.regulator_en;
  endproperty
  a_strap_hh: assert property (p_strap_hh) else $error("straps high high left a block on");
  property p_strap_hl;
    $past(sa, 2) && $past(sa) && sa |-> !pwr_out.tripler_en;
  endproperty
  a_strap_hl: assert property (p_strap_hl) else $error("straps high low left tripler on");
endmodule

bind lcdt_line_timing lcdt_line_timing_monitor u_mon (.clk_sys(clk_sys), .rst(rst), .variant(variant),
  .master_mode(master_mode), .pwr_in(pwr_in), .frame_sync_out(frame_sync_out), .frame_sync_oe(frame_sync_oe),
  .divided_clk_oe(divided_clk_oe), .common_start_pulse(common_start_pulse), .output_config(output_config),
  .pwr_out(pwr_out));

/* File: test/lcdt_master_model.sv */
module lcdt_master_model #(
  parameter int DIV = 8,
  parameter int DUTY = 8
) (
  input wire logic clk_sys,
  input wire logic run,
  output logic display_clk,
  output logic frame_sync,
  output logic frame_polarity
);
  timeunit 1ns;
  timeprecision 100ps;
  int ph = 0;
  int line = 0;
  initial begin
    display_clk = 1'b0;
    frame_sync = 1'b0;
    frame_polarity = 1'b0;
  end
  // The clock stands still while not running, as the chip's divided clock does in slave mode.
  always @(posedge clk_sys) begin
    if (!run) begin
      display_clk <= 1'b0;
      ph <= 0;
    end else if (ph == DIV - 1) begin
      ph <= 0;
      display_clk <= !display_clk;
      if (display_clk) begin
        line <= (line == DUTY - 1) ? 0 : line + 1;
        frame_sync <= ((line == DUTY - 1) ? 0 : line + 1) < DUTY / 2;
        if (line == DUTY - 1) frame_polarity <= !frame_polarity;
      end
    end else begin
      ph <= ph + 1;
    end
  end
endmodule

/* File: test/lcdt_line_timing_tb.sv */
module lcdt_line_timing_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import lcdt_pkg::*;
  logic clk_sys, rst, master_mode, osc_in, display_clk, cfg_we, run, frame_polarity_in, frame_sync_in;
  lcdt_variant_t variant;
  logic [3:0] cfg_wdata, exp;
  lcdt_disp_cfg_t disp_cfg;
  logic [5:0] start_line;
  logic [165:0] ram_row, row_latch;
  lcdt_pwr_in_t pwr_in;
  lcdt_pwr_out_t pwr_out;
  logic [6:0] ram_line_addr;
  logic frame_polarity_out, frame_polarity_oe, frame_sync_out, frame_sync_oe;
  logic divided_clk_out, divided_clk_oe, common_start_pulse, osc_out;
  logic [3:0] output_config;
  logic [95:0] dual_is_com, com_scan;
  logic [333:0] out_level;
  int num_errors = 0;
  int n_compared = 0;
  int n, m;
  bit ok;
  lcdt_line_timing uut (.clk_sys, .rst, .variant, .master_mode, .osc_in, .display_clk, .cfg_we, .cfg_wdata,
    .disp_cfg, .start_line, .ram_row, .frame_polarity_in, .frame_sync_in, .pwr_in, .ram_line_addr, .row_latch,
    .frame_polarity_out, .frame_polarity_oe, .frame_sync_out, .frame_sync_oe, .divided_clk_out, .divided_clk_oe,
    .common_start_pulse, .osc_out, .output_config, .dual_is_com, .com_scan, .out_level, .pwr_out);
  lcdt_master_model #(.DIV(8), .DUTY(8)) u_far (.clk_sys(clk_sys), .run(run), .display_clk(display_clk),
    .frame_sync(frame_sync_in), .frame_polarity(frame_polarity_in));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = !clk_sys;
  end
  task automatic check(input logic [165:0] got, input logic [165:0] want);
    n_compared++;
    if (got !== want) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  function automatic logic [95:0] com_exp(input int v, input logic [2:0] c);
    logic [95:0] w;
    w = '0;
    if (v == 2) w[95:80] = '1;
    else if (c == 3'h5) w[95:32] = '1;
    else if (c == 3'h4) begin
      w[31:0] = '1;
      w[95:64] = '1;
    end else if (c == 3'h3) w[31:0] = '1;
    else if (c == 3'h2) w[95:64] = '1;
    else if (c == 3'h1) begin
      w[15:0] = '1;
      w[95:80] = '1;
    end
    com_exp = w;
  endfunction
  task automatic print_verdict;
    if (num_errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic do_reset(input lcdt_variant_t v);
    @(posedge clk_sys);
    rst <= 1'b1;
    variant <= v;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
  endtask
  // Counts cycles until the chosen timing output changes, bounded so a stuck line cannot hang.
  task automatic wait_chg(input bit sel, output int cnt);
    logic v;
    @(negedge clk_sys);
    v = sel ? frame_polarity_out : frame_sync_out;
    cnt = 1;
    while ((sel ? frame_polarity_out : frame_sync_out) === v && cnt < 500) begin
      @(negedge clk_sys);
      cnt++;
    end
  endtask
  initial begin
    rst = 1'b1; variant = LCDT_VAR_LARGE; master_mode = 1'b1; osc_in = 1'b0; cfg_we = 1'b0; run = 1'b0;
    cfg_wdata = 4'h0; disp_cfg = '0; start_line = 6'h05; ram_row = {83{2'h2}}; pwr_in = '0;
    disp_cfg.duty = 7'h08;
    disp_cfg.display_on = 1'b1;
    for (int v = 0; v < 3; v++) begin
      do_reset(lcdt_variant_t'(v));
      exp = 4'h0;
      for (int k = 0; k < 8; k++) begin
        ok = (v == 0) ? (k == 5 || k == 4 || k == 0) : (v == 1) ? (k < 4) : 1'b0;
        @(posedge clk_sys);
        cfg_we <= 1'b1;
        cfg_wdata <= {1'b1, 3'(k)};
        @(posedge clk_sys);
        cfg_we <= 1'b0;
        @(negedge clk_sys);
        if (ok) exp = {1'b1, 3'(k)};
        check(output_config, exp);
        @(negedge clk_sys);
        check(dual_is_com, com_exp(v, exp[2:0]));
      end
    end
    do_reset(LCDT_VAR_LARGE);
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    check({frame_sync_oe, frame_polarity_oe, divided_clk_oe}, 3'h7);
    check(osc_out, 1'b1);
    ok = divided_clk_out;
    n = 0;
    repeat (16) begin
      @(negedge clk_sys);
      if (divided_clk_out !== ok) n++;
      ok = divided_clk_out;
    end
    check(n, 8);
    wait_chg(1'b0, n);
    wait_chg(1'b0, n);
    wait_chg(1'b0, m);
    check(n, 16);
    check(m, 16);
    wait_chg(1'b1, n);
    wait_chg(1'b1, n);
    check(n, 32);
    check(ram_line_addr, 7'h05);
    check(com_scan, 96'h1);
    @(posedge clk_sys);
    disp_cfg.line_inv_en <= 1'b1;
    disp_cfg.line_inv_n <= 6'h02;
    wait_chg(1'b1, n);
    wait_chg(1'b1, n);
    wait_chg(1'b1, n);
    check(n, 8);
    check(row_latch, ram_row);
    @(posedge clk_sys);
    disp_cfg.all_points_on <= 1'b1;
    repeat (40) @(posedge clk_sys);
    check(row_latch, {166{1'b1}});
    disp_cfg.all_points_on <= 1'b0;
    disp_cfg.normal_inverse <= 1'b1;
    repeat (40) @(posedge clk_sys);
    check(row_latch, ~ram_row);
    for (int i = 0; i < 3; i++) begin
      pwr_in <= '{1'b1, i > 0, i > 1};
      repeat (6) @(posedge clk_sys);
      check(pwr_out, (i == 0) ? 3'h7 : (i == 1) ? 3'h3 : 3'h1);
    end
    pwr_in <= '0;
    master_mode <= 1'b0;
    run <= 1'b1;
    repeat (200) @(posedge clk_sys);
    @(negedge clk_sys);
    check({frame_sync_oe, frame_polarity_oe, divided_clk_oe}, 3'h0);
    check(osc_out, 1'b0);
    n = 0;
    while (common_start_pulse !== 1'b1 && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    m = 0;
    do begin
      @(negedge clk_sys);
      m++;
    end while (common_start_pulse !== 1'b1 && m < 200);
    check(m, 64);
    check(frame_polarity_out, frame_polarity_in);
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    print_verdict();
  end
endmodule
